// ---- pbc_top.sv ----
// pci boot configuration decoder with apb register access
`timescale 1ns/100ps
`default_nettype none
module pbc_top
#(
   parameter logic [15:0] DFLT_DEVICE_ID  = 16'h0001, // arbitrary value
   parameter logic [15:0] DFLT_VENDOR_ID  = 16'h0001, // arbitrary value
   parameter logic [23:0] DFLT_CLASS_CODE = 24'h000000,
   parameter logic [7:0]  DFLT_REVISION   = 8'h00,     // arbitrary value
   parameter logic [15:0] DFLT_SUBSYS_ID  = 16'h0000, // arbitrary value
   parameter logic [15:0] DFLT_SUBSYS_VEN = 16'h0000  // arbitrary value
)
(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // boot configuration sources
   input  wire logic [1:0]   boot_mode_select,
   input  wire logic [7:0]   local_bus_addr_data_straps,
   input  wire logic [127:0] serial_reset_config_word,
   // apb slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // configuration outputs
   output logic              cfg_loaded,
   output logic              pci_enabled_at_boot,
   output logic              ad_bus_for_pci,
   output logic      [15:0]  pci_pin_assign_reg,
   output logic      [3:0]   req_gnt_for_pci,
   output logic              pci_pad_slew_reg,
   output logic              irq_pin_assign_reg,
   output logic              cfg_retry,
   output logic      [5:0]   bar_enable,
   output logic              host_mode,
   output logic      [31:0]  pci_identity_reg,
   output logic      [31:0]  pci_class_revision_reg,
   output logic      [31:0]  pci_subsystem_identity_reg
);

   // ======================================================================
   // helpers
   function automatic logic pair_is_pci(input logic [15:0] pin,
                                        input int          idx);
      logic [1:0] req_f;
      logic [1:0] gnt_f;
      req_f = pin[2*idx +: 2];
      gnt_f = pin[8 + 2*idx +: 2];
      pair_is_pci = (req_f != 2'h0) && (gnt_f != 2'h0);
   endfunction

   function automatic logic strap_pci_on(input logic [7:0] strap);
      logic [2:0] cfg_f;
      cfg_f = strap[pbc_pkg::PBC_STRAP_CFG_MSB:pbc_pkg::PBC_STRAP_CFG_LSB];
      strap_pci_on = (cfg_f == 3'h3) || (cfg_f == 3'h7);
   endfunction

   // ======================================================================
   // boot decode
   pbc_pkg::pbc_boot_type boot_mode;
   logic                  boot_pcien;
   logic                  boot_slew;
   logic                  boot_irq;
   logic                  boot_retry;
   logic [5:0]            boot_bar;
   logic                  boot_host;
   logic [31:0]           boot_identity;
   logic [31:0]           boot_class_rev;
   logic [31:0]           boot_subsys;
   logic [127:0]          w;
   logic [7:0]            s;

   assign w         = serial_reset_config_word;
   assign s         = local_bus_addr_data_straps;
   assign boot_mode = pbc_pkg::pbc_boot_type'(boot_mode_select);

   always_comb
   begin
      boot_identity  = {DFLT_DEVICE_ID, DFLT_VENDOR_ID};
      boot_class_rev = {DFLT_CLASS_CODE, DFLT_REVISION};
      boot_subsys    = {DFLT_SUBSYS_ID, DFLT_SUBSYS_VEN};
      case (boot_mode)
         pbc_pkg::PBC_BOOT_PARALLEL:
         begin
            boot_pcien = strap_pci_on(s);
            boot_slew  = s[pbc_pkg::PBC_STRAP_SLEW];
            if (s[pbc_pkg::PBC_STRAP_HOST])
            begin
               boot_irq   = 1'b0;
               boot_retry = 1'b0;
               boot_bar   = pbc_pkg::PBC_BAR_ALL;
               boot_host  = 1'b1;
            end
            else
            begin
               boot_irq   = 1'b1;
               boot_retry = 1'b1;
               boot_bar   = pbc_pkg::PBC_BAR_NONE;
               boot_host  = 1'b0;
            end
         end
         pbc_pkg::PBC_BOOT_SERIAL:
         begin
            boot_pcien = w[pbc_pkg::PBC_WORD_PCIEN];
            boot_slew  = w[pbc_pkg::PBC_WORD_SLEW];
            boot_irq   = w[pbc_pkg::PBC_WORD_IRQ];
            boot_retry = w[pbc_pkg::PBC_WORD_RETRY];
            boot_bar   = w[pbc_pkg::PBC_WORD_BAR_LSB +: 6];
            boot_host  = ~w[pbc_pkg::PBC_WORD_IRQ];
            boot_identity  = {w[pbc_pkg::PBC_WORD_DEV_LSB +: 16],
                              w[pbc_pkg::PBC_WORD_VEN_LSB +: 16]};
            boot_class_rev = {w[pbc_pkg::PBC_WORD_CLS_LSB +: 24],
                              w[pbc_pkg::PBC_WORD_REV_LSB +: 8]};
            boot_subsys    = {w[pbc_pkg::PBC_WORD_SID_LSB +: 16],
                              w[pbc_pkg::PBC_WORD_SVN_LSB +: 16]};
         end
         default:
         begin
            // default and the unassigned code both give a host setup
            boot_pcien = 1'b1;
            boot_slew  = 1'b1;
            boot_irq   = 1'b0;
            boot_retry = 1'b0;
            boot_bar   = pbc_pkg::PBC_BAR_ALL;
            boot_host  = 1'b1;
         end
      endcase
   end

   // ======================================================================
   // one-shot load after reset release
   logic load;

   assign load = ~cfg_loaded;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_loaded <= 1'b0;
      else
         cfg_loaded <= 1'b1;
   end

   // ======================================================================
   // apb decode
   logic        acc;
   logic        wr_ok;
   logic [7:0]  ofs;
   logic        mapped;

   assign acc   = psel & penable & ~pready;
   assign wr_ok = psel & penable & pready & pwrite & ~pslverr & cfg_loaded;
   assign ofs   = {paddr[7:2], 2'b00};

   always_comb
   begin
      case (ofs)
         pbc_pkg::PBC_OFS_PIN_ASSIGN,
         pbc_pkg::PBC_OFS_PAD_SLEW,
         pbc_pkg::PBC_OFS_IRQ_ASSIGN,
         pbc_pkg::PBC_OFS_TGT_CTRL2,
         pbc_pkg::PBC_OFS_CHIP_STAT,
         pbc_pkg::PBC_OFS_IDENTITY,
         pbc_pkg::PBC_OFS_CLASS_REV,
         pbc_pkg::PBC_OFS_SUBSYS_ID: mapped = 1'b1;
         default:                    mapped = 1'b0;
      endcase
   end

   // ======================================================================
   // boot-fixed state
   pbc_pkg::pbc_boot_type boot_mode_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pci_enabled_at_boot <= 1'b0;
         ad_bus_for_pci      <= 1'b0;
         host_mode           <= 1'b0;
         boot_mode_r         <= pbc_pkg::PBC_BOOT_DEFAULT;
      end
      else if (load)
      begin
         pci_enabled_at_boot <= boot_pcien;
         ad_bus_for_pci      <= boot_pcien;
         host_mode           <= boot_host;
         boot_mode_r         <= boot_mode;
      end
   end

   // ======================================================================
   // pin assignment and request/grant routing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pci_pin_assign_reg <= pbc_pkg::PBC_PIN_NONE;
      else if (load)
         pci_pin_assign_reg <= boot_pcien ? pbc_pkg::PBC_PIN_PCI
                                          : pbc_pkg::PBC_PIN_NONE;
      else if (wr_ok && ofs == pbc_pkg::PBC_OFS_PIN_ASSIGN)
         pci_pin_assign_reg <= pwdata[15:0];
   end

   logic [15:0] pin_next;

   assign pin_next = load ? (boot_pcien ? pbc_pkg::PBC_PIN_PCI
                                        : pbc_pkg::PBC_PIN_NONE)
                   : (wr_ok && ofs == pbc_pkg::PBC_OFS_PIN_ASSIGN)
                     ? pwdata[15:0] : pci_pin_assign_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         req_gnt_for_pci <= 4'h0;
      else
      begin
         for (int i = 0; i < 4; i++)
            req_gnt_for_pci[i] <= pair_is_pci(pin_next, i);
      end
   end

   // ======================================================================
   // pad slew
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pci_pad_slew_reg <= 1'b0;
      else if (load)
         pci_pad_slew_reg <= boot_slew;
      else if (wr_ok && ofs == pbc_pkg::PBC_OFS_PAD_SLEW)
         pci_pad_slew_reg <= pwdata[pbc_pkg::PBC_SLEW_BIT];
   end

   // ======================================================================
   // interrupt pin assignment
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_pin_assign_reg <= 1'b0;
      else if (load)
         irq_pin_assign_reg <= boot_irq;
      else if (wr_ok && ofs == pbc_pkg::PBC_OFS_IRQ_ASSIGN)
         irq_pin_assign_reg <= pwdata[pbc_pkg::PBC_IRQ_BIT];
   end

   // ======================================================================
   // target control: retry and bar enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_retry  <= 1'b0;
         bar_enable <= pbc_pkg::PBC_BAR_NONE;
      end
      else if (load)
      begin
         cfg_retry  <= boot_retry;
         bar_enable <= boot_bar;
      end
      else if (wr_ok && ofs == pbc_pkg::PBC_OFS_TGT_CTRL2)
      begin
         cfg_retry  <= pwdata[pbc_pkg::PBC_RETRY_BIT];
         bar_enable <= pwdata[pbc_pkg::PBC_BAR_LSB +: 6];
      end
   end

   // ======================================================================
   // identification store
   logic [31:0] id_rd_data;
   logic [1:0]  id_idx;

   always_comb
   begin
      case (ofs)
         pbc_pkg::PBC_OFS_CLASS_REV: id_idx = pbc_pkg::PBC_IDX_CLASS_REV;
         pbc_pkg::PBC_OFS_SUBSYS_ID: id_idx = pbc_pkg::PBC_IDX_SUBSYS_ID;
         default:                    id_idx = pbc_pkg::PBC_IDX_IDENTITY;
      endcase
   end

   // no write port: these stay at their boot values
   pbc_id_store u_id_store
   (
      .pclk        (pclk),
      .presetn     (presetn),
      .load        (load),
      .identity_in (boot_identity),
      .class_rev_in(boot_class_rev),
      .subsys_in   (boot_subsys),
      .rd_idx      (id_idx),
      .rd_data     (id_rd_data),
      .identity_r  (pci_identity_reg),
      .class_rev_r (pci_class_revision_reg),
      .subsys_r    (pci_subsystem_identity_reg)
   );

   // ======================================================================
   // apb read mux and response
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = 32'h00000000;
      case (ofs)
         pbc_pkg::PBC_OFS_PIN_ASSIGN:
            rd_mux[15:0] = pci_pin_assign_reg;
         pbc_pkg::PBC_OFS_PAD_SLEW:
            rd_mux[pbc_pkg::PBC_SLEW_BIT] = pci_pad_slew_reg;
         pbc_pkg::PBC_OFS_IRQ_ASSIGN:
            rd_mux[pbc_pkg::PBC_IRQ_BIT] = irq_pin_assign_reg;
         pbc_pkg::PBC_OFS_TGT_CTRL2:
         begin
            rd_mux[pbc_pkg::PBC_RETRY_BIT]    = cfg_retry;
            rd_mux[pbc_pkg::PBC_BAR_LSB +: 6] = bar_enable;
         end
         pbc_pkg::PBC_OFS_CHIP_STAT:
         begin
            rd_mux[pbc_pkg::PBC_PCIEN_BIT]     = pci_enabled_at_boot;
            rd_mux[pbc_pkg::PBC_HOST_BIT]      = host_mode;
            rd_mux[pbc_pkg::PBC_MODE_LSB +: 2] = boot_mode_r;
         end
         pbc_pkg::PBC_OFS_IDENTITY,
         pbc_pkg::PBC_OFS_CLASS_REV,
         pbc_pkg::PBC_OFS_SUBSYS_ID:
            rd_mux = id_rd_data;
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else if (acc)
      begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= (pwrite || !mapped) ? 32'h00000000 : rd_mux;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
   end

endmodule
`default_nettype wire

// ---- pbc_pkg.sv ----
// constants and types shared by the pci boot configuration decoder
`default_nettype none
package pbc_pkg;

   // =====================================================================
   // boot mode select codes
   typedef enum logic [1:0]
   {
      PBC_BOOT_DEFAULT  = 2'h0,
      PBC_BOOT_RSVD     = 2'h1,
      PBC_BOOT_PARALLEL = 2'h2,
      PBC_BOOT_SERIAL   = 2'h3
   } pbc_boot_type;

   // =====================================================================
   // apb register byte offsets
   localparam logic [7:0]  PBC_OFS_PIN_ASSIGN = 8'h00;
   localparam logic [7:0]  PBC_OFS_PAD_SLEW   = 8'h04;
   localparam logic [7:0]  PBC_OFS_IRQ_ASSIGN = 8'h08;
   localparam logic [7:0]  PBC_OFS_TGT_CTRL2  = 8'h0C;
   localparam logic [7:0]  PBC_OFS_CHIP_STAT  = 8'h10;
   localparam logic [7:0]  PBC_OFS_IDENTITY   = 8'h14;
   localparam logic [7:0]  PBC_OFS_CLASS_REV  = 8'h18;
   localparam logic [7:0]  PBC_OFS_SUBSYS_ID  = 8'h1C;

   // =====================================================================
   // field positions inside the registers
   localparam int          PBC_SLEW_BIT       = 0;
   localparam int          PBC_IRQ_BIT        = 1;
   localparam int          PBC_RETRY_BIT      = 0;
   localparam int          PBC_BAR_LSB        = 8;
   localparam int          PBC_BAR_W          = 6;
   localparam int          PBC_HOST_BIT       = 3;
   localparam int          PBC_PCIEN_BIT      = 0;
   localparam int          PBC_MODE_LSB       = 4;

   // =====================================================================
   // boot values
   localparam logic [15:0] PBC_PIN_PCI        = 16'hD5D5;
   localparam logic [15:0] PBC_PIN_NONE       = 16'h0000;
   localparam logic [5:0]  PBC_BAR_ALL        = 6'h3F;
   localparam logic [5:0]  PBC_BAR_NONE       = 6'h00;

   // =====================================================================
   // parallel strap positions
   localparam int          PBC_STRAP_W        = 8;
   localparam int          PBC_STRAP_SLEW     = 2;
   localparam int          PBC_STRAP_HOST     = 3;
   localparam int          PBC_STRAP_CFG_LSB  = 5;
   localparam int          PBC_STRAP_CFG_MSB  = 7;

   // =====================================================================
   // serial configuration word positions
   localparam int          PBC_WORD_W         = 128;
   localparam int          PBC_WORD_PCIEN     = 125;
   localparam int          PBC_WORD_SLEW      = 104;
   localparam int          PBC_WORD_IRQ       = 103;
   localparam int          PBC_WORD_RETRY     = 102;
   localparam int          PBC_WORD_BAR_LSB   = 96;
   localparam int          PBC_WORD_DEV_LSB   = 80;
   localparam int          PBC_WORD_VEN_LSB   = 64;
   localparam int          PBC_WORD_CLS_LSB   = 40;
   localparam int          PBC_WORD_REV_LSB   = 32;
   localparam int          PBC_WORD_SID_LSB   = 16;
   localparam int          PBC_WORD_SVN_LSB   = 0;

   // =====================================================================
   // identification store word indices
   localparam logic [1:0]  PBC_IDX_IDENTITY   = 2'h0;
   localparam logic [1:0]  PBC_IDX_CLASS_REV  = 2'h1;
   localparam logic [1:0]  PBC_IDX_SUBSYS_ID  = 2'h2;

endpackage
`default_nettype wire

// ---- pbc_id_store.sv ----
// read-only identification word store, loaded once after reset
`timescale 1ns/100ps
`default_nettype none
module pbc_id_store
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // load side
   input  wire logic        load,
   input  wire logic [31:0] identity_in,
   input  wire logic [31:0] class_rev_in,
   input  wire logic [31:0] subsys_in,
   // read side
   input  wire logic [1:0]  rd_idx,
   output logic      [31:0] rd_data,
   // held words
   output logic      [31:0] identity_r,
   output logic      [31:0] class_rev_r,
   output logic      [31:0] subsys_r
);

   // ======================================================================
   // storage, no software write path
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         identity_r  <= 32'h00000000;
         class_rev_r <= 32'h00000000;
         subsys_r    <= 32'h00000000;
      end
      else if (load)
      begin
         identity_r  <= identity_in;
         class_rev_r <= class_rev_in;
         subsys_r    <= subsys_in;
      end
   end

   // ======================================================================
   // registered read port
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_data <= 32'h00000000;
      else
      begin
         case (rd_idx)
            pbc_pkg::PBC_IDX_IDENTITY:  rd_data <= identity_r;
            pbc_pkg::PBC_IDX_CLASS_REV: rd_data <= class_rev_r;
            pbc_pkg::PBC_IDX_SUBSYS_ID: rd_data <= subsys_r;
            default:                    rd_data <= 32'h00000000;
         endcase
      end
   end

endmodule
`default_nettype wire

// ---- pbc_top_asserts.sv ----
// concurrent checks on the ports of the boot configuration decoder
`timescale 1ns/100ps
`default_nettype none
module pbc_top_asserts
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // boot and apb side
   input  wire logic [1:0]  boot_mode_select,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // configuration outputs
   input  wire logic        cfg_loaded,
   input  wire logic        pci_enabled_at_boot,
   input  wire logic        ad_bus_for_pci,
   input  wire logic [15:0] pci_pin_assign_reg,
   input  wire logic [3:0]  req_gnt_for_pci,
   input  wire logic        pci_pad_slew_reg,
   input  wire logic        irq_pin_assign_reg,
   input  wire logic        host_mode,
   input  wire logic [31:0] pci_identity_reg
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // =================================================================
   // pair use implied by the pin assignment
   logic [3:0] rg_exp;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         rg_exp[i] = (|pci_pin_assign_reg[2*i+:2])
                     && (|pci_pin_assign_reg[8+2*i+:2]);
   end

   // =================================================================
   // properties
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("answer not one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held over two cycles");
   a_err_nodata: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   a_load_prompt: assert property (!cfg_loaded |=> cfg_loaded)
      else $error("boot values not loaded at first edge");
   a_boot_fixed: assert property (cfg_loaded |=>
      $stable(ad_bus_for_pci) && $stable(pci_identity_reg))
      else $error("boot-only value changed at run time");
   a_ad_owner: assert property (cfg_loaded |->
      ad_bus_for_pci == pci_enabled_at_boot)
      else $error("address bus owner differs from boot enable");
   a_boot_pin: assert property ($rose(cfg_loaded) |->
      pci_pin_assign_reg == (pci_enabled_at_boot ? 16'hD5D5 : 16'h0000))
      else $error("boot pin assignment wrong");
   a_serial_host: assert property ($rose(cfg_loaded)
      && boot_mode_select == 2'h3 |-> host_mode == !irq_pin_assign_reg)
      else $error("serial host indicator not inverse of irq bit");
   a_pair_use: assert property (
      cfg_loaded |-> req_gnt_for_pci == rg_exp)
      else $error("request grant use differs from pin assign");
   a_slew_write: assert property (psel && penable && pready && pwrite
      && paddr[7:2] == 6'h01 |=> pci_pad_slew_reg == $past(pwdata[0]))
      else $error("pad slew write not applied");
endmodule

bind pbc_top pbc_top_asserts u_asserts
(
   .pclk, .presetn, .boot_mode_select, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .cfg_loaded, .pci_enabled_at_boot,
   .ad_bus_for_pci, .pci_pin_assign_reg, .req_gnt_for_pci,
   .pci_pad_slew_reg, .irq_pin_assign_reg, .host_mode, .pci_identity_reg
);
`default_nettype wire

// ---- pbc_boot_src.sv ----
// boot source model: mode pins, straps and serial memory
`timescale 1ns/100ps
`default_nettype none
module pbc_boot_src
(
   // settings from the bench
   input  wire logic [1:0]   mode_set,
   input  wire logic [7:0]   strap_set,
   input  wire logic [127:0] word_set,
   // pins toward the decoder
   output logic      [1:0]   boot_mode_select,
   output logic      [7:0]   local_bus_addr_data_straps,
   output logic      [127:0] serial_reset_config_word
);
   assign boot_mode_select = mode_set;
   assign local_bus_addr_data_straps = strap_set;
   // memory drives its word in serial mode only, else junk
   assign serial_reset_config_word = (mode_set == 2'h3) ? word_set
                                     : ~word_set;
endmodule
`default_nettype wire

// ---- pci_boot_config_decoder_tb.sv ----
// self-checking bench for the boot configuration decoder
`timescale 1ns/100ps
`default_nettype none
module pci_boot_config_decoder_tb;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]   paddr, strap, local_bus_addr_data_straps;
   logic [31:0]  pwdata, prdata, st;
   logic [1:0]   mode, boot_mode_select;
   logic [127:0] word, serial_reset_config_word;
   logic         cfg_loaded, pci_enabled_at_boot, ad_bus_for_pci;
   logic         pci_pad_slew_reg, irq_pin_assign_reg, cfg_retry, host_mode;
   logic [15:0]  pci_pin_assign_reg;
   logic [3:0]   req_gnt_for_pci;
   logic [5:0]   bar_enable;
   logic [31:0]  pci_identity_reg, pci_class_revision_reg;
   logic [31:0]  pci_subsystem_identity_reg;
   logic [31:0]  e_reg [8];
   int           n_fail, num_checks;

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   pbc_boot_src u_src (.mode_set(mode), .strap_set(strap),
      .word_set(word), .boot_mode_select, .local_bus_addr_data_straps,
      .serial_reset_config_word);
   pbc_top #(.DFLT_DEVICE_ID(16'h1234), .DFLT_VENDOR_ID(16'h5678)) uut
   (
      .pclk, .presetn, .boot_mode_select, .local_bus_addr_data_straps,
      .serial_reset_config_word, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cfg_loaded, .pci_enabled_at_boot,
      .ad_bus_for_pci, .pci_pin_assign_reg, .req_gnt_for_pci,
      .pci_pad_slew_reg, .irq_pin_assign_reg, .cfg_retry, .bar_enable,
      .host_mode, .pci_identity_reg, .pci_class_revision_reg,
      .pci_subsystem_identity_reg
   );

   // =================================================================
   // helpers
   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction

   function automatic logic [3:0] pairs(input logic [15:0] p);
      for (int i = 0; i < 4; i++)
         pairs[i] = (|p[2*i+:2]) && (|p[8+2*i+:2]);
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 64);
      if (k >= 64)
      begin
         n_fail++;
         $display("unexpected pready: expected 1, seen %b", pready);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // =================================================================
   // one boot: model, reset, register and run-time checks
   task automatic boot(input logic [1:0] m, input logic [7:0] s,
                       input logic [127:0] w);
      logic        en, sl, h, ir, rt, er;
      logic [5:0]  b;
      logic [31:0] q, r;
      en = 1'b1; sl = 1'b1; h = 1'b1; ir = 1'b0; rt = 1'b0; b = 6'h3F;
      e_reg[5] = 32'h12345678;
      e_reg[6] = 32'h0;
      e_reg[7] = 32'h0;
      if (m == 2'h2)
      begin
         en = (s[6:5] == 2'h3);
         sl = s[2];
         h = s[3];
         ir = !h;
         rt = !h;
         b = h ? 6'h3F : 6'h00;
      end
      if (m == 2'h3)
      begin
         {en, sl, ir, rt, b} = {w[125], w[104:96]};
         h = !w[103];
         {e_reg[5], e_reg[6], e_reg[7]} = w[95:0];
      end
      e_reg[0] = en ? 32'h0000D5D5 : 32'h0;
      e_reg[1] = {31'h0, sl};
      e_reg[2] = {30'h0, ir, 1'b0};
      e_reg[3] = {18'h0, b, 7'h0, rt};
      e_reg[4] = {26'h0, m, h, 2'h0, en};
      @(posedge pclk);
      mode <= m;
      strap <= s;
      word <= w;
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("ad owner", 32'(en), 32'(ad_bus_for_pci));
      chk("pairs", en ? 32'hF : 32'h0, 32'(req_gnt_for_pci));
      chk("bars", 32'(b), 32'(bar_enable));
      chk("host", 32'(h), 32'(host_mode));
      chk("loaded", 32'h1, 32'(cfg_loaded));
      chk("pci enabled", 32'(en), 32'(pci_enabled_at_boot));
      chk("pin out", e_reg[0], 32'(pci_pin_assign_reg));
      chk("slew out", 32'(sl), 32'(pci_pad_slew_reg));
      chk("irq out", 32'(ir), 32'(irq_pin_assign_reg));
      chk("retry out", 32'(rt), 32'(cfg_retry));
      chk("identity out", e_reg[5], pci_identity_reg);
      chk("class out", e_reg[6], pci_class_revision_reg);
      chk("subsys out", e_reg[7], pci_subsystem_identity_reg);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0, q, er);
         chk("register", e_reg[i], q);
      end
      apb(1'b1, 8'h14, rnd(), q, er);
      apb(1'b0, 8'h14, 32'h0, q, er);
      chk("identity", e_reg[5], q);
      r = rnd();
      apb(1'b1, 8'h00, r, q, er);
      @(negedge pclk);
      chk("pin assign", 32'(r[15:0]), 32'(pci_pin_assign_reg));
      chk("pairs", 32'(pairs(r[15:0])), 32'(req_gnt_for_pci));
      chk("ad owner", 32'(en), 32'(ad_bus_for_pci));
      apb(1'b1, 8'h04, 32'(!sl), q, er);
      @(negedge pclk);
      chk("slew", 32'(!sl), 32'(pci_pad_slew_reg));
      apb(1'b0, 8'h20, 32'h0, q, er);
      chk("unmapped error", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, q);
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      give_verdict();
   end

   initial
   begin
      logic [31:0]  r;
      logic [127:0] w;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; mode = 2'h0; strap = 8'h00;
      word = '0; st = 32'hE3D9; n_fail = 0; num_checks = 0;
      boot(2'h0, 8'h00, '0);
      boot(2'h1, 8'hFF, '0);
      for (int i = 0; i < 8; i++)
      begin
         r = rnd();
         boot(2'h2, {3'(i), r[4], i[1] ^ i[2], r[2:0]}, '0);
      end
      for (int i = 0; i < 3; i++)
      begin
         w = {rnd(), rnd(), rnd(), rnd()};
         w[103] = i[0];
         boot(2'h3, 8'h00, w);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
